// ### src/mbl_regs.vh
// Constants for the serial link configuration block
`ifndef MBL_REGS_VH
`define MBL_REGS_VH
`define MBL_CLK_HZ 25000000
`define MBL_ADDR_MAX 8'hC7
`define MBL_ADDR_BCAST 8'hFF
`define MBL_REG_OPEN_A 8'h04
`define MBL_REG_OPEN_B 8'h05
`define MBL_TIMEOUT_MAX 7'h63
`define MBL_BITS_PER_CHAR 20'h0000B
`define MBL_PERIOD_1200 16'h5161
`define MBL_PERIOD_2400 16'h28B1
`define MBL_PERIOD_4800 16'h1458
`define MBL_PERIOD_9600 16'h0A2C
`define MBL_PERIOD_19200 16'h0516
`define MBL_PERIOD_38400 16'h028B
`define MBL_PERIOD_57600 16'h01B2
`define MBL_PERIOD_115200 16'h00D9
`define MBL_DELAY_NONE 8'h00
`define MBL_DELAY_10 8'h0A
`define MBL_DELAY_20 8'h14
`define MBL_DELAY_50 8'h32
`define MBL_DELAY_100 8'h64
`define MBL_DELAY_200 8'hC8
`define MBL_RST_PERIOD 16'h0000
`define MBL_SEC_CYCLES 25000000
`endif

// ### src/mbl_link_cfg.v
// Serial link configuration: address match, rate, write gate, frame timeout, reply delay
`timescale 1ns/1ns
// Summary of operation
// - The station address setting of 0 to 199 decides which received frames are ours.
// - With station address zero the device answers frames addressed to 255 instead.
// - The rate select picks one of eight bit rates from 1200 to 115200 and sets link timing.
// - Remote configuration writes to registers other than 04h and 05h take effect only while the write enable is on.
// - Registers 04h and 05h stay writable whatever the write enable says.
// - A gap between received frames longer than the timeout forces remote relays to alert.
// - The timeout spans 0 to 99 seconds and zero disables supervision.
// - With no extra delay selected the reply is released as soon as reply ready is high.
// - Other delay options add 10, 20, 50, 100 or 200 character times.
`include "mbl_regs.vh"
module mbl_link_cfg #(
	parameter SEC_CYCLES = `MBL_SEC_CYCLES
) (
	// Clock and reset
	input wire clk_sys_in,
	input wire srst_in,
	// Configuration
	input wire [7:0] station_address_in,
	input wire [2:0] line_rate_select_in,
	input wire remote_config_write_enable_in,
	input wire [6:0] frame_gap_timeout_in,
	input wire [2:0] reply_delay_select_in,
	// Received frame events from the framer
	input wire frame_end_in,
	input wire [7:0] frame_addr_in,
	input wire cfg_write_in,
	input wire [7:0] cfg_write_reg_in,
	input wire [15:0] cfg_write_data_in,
	// Reply handshake
	input wire reply_ready_in,
	// Outputs
	output reg [15:0] bit_period_out,
	output reg addr_match_out,
	output reg cfg_write_out,
	output reg [7:0] cfg_write_reg_out,
	output reg [15:0] cfg_write_data_out,
	output reg cfg_write_refused_out,
	output reg relay_alert_out,
	output reg reply_go_out
);

// ----------------------------------------
// Rate table
// ----------------------------------------
// Periods rounded to the nearest clock at 25 MHz
function [15:0] rate_period;
	input [2:0] sel;
	begin
		case (sel)
			3'h0: rate_period = `MBL_PERIOD_1200;
			3'h1: rate_period = `MBL_PERIOD_2400;
			3'h2: rate_period = `MBL_PERIOD_4800;
			3'h3: rate_period = `MBL_PERIOD_9600;
			3'h4: rate_period = `MBL_PERIOD_19200;
			3'h5: rate_period = `MBL_PERIOD_38400;
			3'h6: rate_period = `MBL_PERIOD_57600;
			default: rate_period = `MBL_PERIOD_115200;
		endcase
	end
endfunction

// ----------------------------------------
// Delay table
// ----------------------------------------
// Unused codes 6 and 7 fall back to no delay
function [7:0] delay_chars;
	input [2:0] sel;
	begin
		case (sel)
			3'h1: delay_chars = `MBL_DELAY_10;
			3'h2: delay_chars = `MBL_DELAY_20;
			3'h3: delay_chars = `MBL_DELAY_50;
			3'h4: delay_chars = `MBL_DELAY_100;
			3'h5: delay_chars = `MBL_DELAY_200;
			default: delay_chars = `MBL_DELAY_NONE;
		endcase
	end
endfunction

// ----------------------------------------
// Internal state
// ----------------------------------------
// Reply sequencer states
localparam [1:0] RPL_IDLE = 2'h0;
localparam [1:0] RPL_COUNT = 2'h1;

wire [19:0] char_cycles;
wire [7:0] own_addr;
wire is_open_reg;
wire in_range;
wire gap_watch_on;
reg [31:0] gap_cnt;
reg [6:0] gap_sec;
reg [19:0] char_cnt;
reg [7:0] chars_left;
reg [1:0] rpl_state;

// ----------------------------------------
// Decoded settings
// ----------------------------------------
// eleven bit times per character
// Twenty bits hold a character at the slowest rate
assign char_cycles = {4'h0, bit_period_out} * `MBL_BITS_PER_CHAR;
assign own_addr = (station_address_in == 8'h00) ? `MBL_ADDR_BCAST : station_address_in;
assign in_range = station_address_in <= `MBL_ADDR_MAX;
assign is_open_reg = (cfg_write_reg_in == `MBL_REG_OPEN_A) || (cfg_write_reg_in == `MBL_REG_OPEN_B);
// zero or out of range switches supervision off
assign gap_watch_on = (frame_gap_timeout_in != 7'h00) && (frame_gap_timeout_in <= `MBL_TIMEOUT_MAX);

// ----------------------------------------
// Line rate
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (srst_in) begin
		bit_period_out <= `MBL_RST_PERIOD;
	end else begin
		bit_period_out <= rate_period(line_rate_select_in);
	end
end

// ----------------------------------------
// Address and write gate
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (srst_in) begin
		addr_match_out <= 1'b0;
		cfg_write_out <= 1'b0;
		cfg_write_reg_out <= 8'h00;
		cfg_write_data_out <= 16'h0000;
		cfg_write_refused_out <= 1'b0;
	end else begin
		addr_match_out <= frame_end_in && in_range && (frame_addr_in == own_addr);
		cfg_write_out <= cfg_write_in && (remote_config_write_enable_in || is_open_reg);
		cfg_write_refused_out <= cfg_write_in && !remote_config_write_enable_in && !is_open_reg;
		// Copies ride with the strobe so both line up
		cfg_write_reg_out <= cfg_write_reg_in;
		cfg_write_data_out <= cfg_write_data_in;
	end
end

// ----------------------------------------
// Frame gap supervision
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (srst_in) begin
		gap_cnt <= 32'h00000000;
		gap_sec <= 7'h00;
		relay_alert_out <= 1'b0;
	end else if (frame_end_in) begin
		gap_cnt <= 32'h00000000;
		gap_sec <= 7'h00;
		relay_alert_out <= 1'b0;
	end else if (!gap_watch_on) begin
		gap_cnt <= 32'h00000000;
		gap_sec <= 7'h00;
		relay_alert_out <= 1'b0;
	end else if (gap_sec >= frame_gap_timeout_in) begin
		// gap too long
		// Counters park here until the next frame or until supervision is switched off
		relay_alert_out <= 1'b1;
	end else if (gap_cnt == SEC_CYCLES - 1) begin
		gap_cnt <= 32'h00000000;
		gap_sec <= gap_sec + 7'h01;
	end else begin
		gap_cnt <= gap_cnt + 32'h00000001;
	end
end

// ----------------------------------------
// Reply delay
// ----------------------------------------
always @(posedge clk_sys_in) begin
	if (srst_in) begin
		rpl_state <= RPL_IDLE;
		char_cnt <= 20'h00000;
		chars_left <= 8'h00;
		reply_go_out <= 1'b0;
	end else begin
		reply_go_out <= 1'b0;
		case (rpl_state)
			RPL_IDLE: begin
				if (addr_match_out) begin
					rpl_state <= RPL_COUNT;
					char_cnt <= 20'h00000;
					chars_left <= delay_chars(reply_delay_select_in);
				end
			end
			RPL_COUNT: begin
				if (chars_left == 8'h00) begin
					if (reply_ready_in) begin
						reply_go_out <= 1'b1;
						rpl_state <= RPL_IDLE;
					end
				end else if (char_cnt >= char_cycles - 20'h00001) begin
					// one character elapsed
					// Compare with >= so a rate change mid-count cannot overrun
					char_cnt <= 20'h00000;
					chars_left <= chars_left - 8'h01;
				end else begin
					char_cnt <= char_cnt + 20'h00001;
				end
			end
			default: begin
				rpl_state <= RPL_IDLE;
			end
		endcase
	end
end

endmodule // mbl_link_cfg

// ### tb/mbl_link_cfg_monitor.sv
// Checker on the link config ports
`timescale 1ns/1ns
module mbl_chk(input wire clk_sys_in, srst_in, frame_end_in, cfg_write_in, remote_config_write_enable_in,
	input wire reply_ready_in, addr_match_out, cfg_write_out, cfg_write_refused_out, reply_go_out, relay_alert_out,
	input wire [7:0] station_address_in, frame_addr_in, cfg_write_reg_in, input wire [15:0] bit_period_out,
	input wire [2:0] line_rate_select_in, reply_delay_select_in, input wire [6:0] frame_gap_timeout_in);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	wire op = cfg_write_reg_in == 8'h04 || cfg_write_reg_in == 8'h05;
	wire ok = station_address_in != 8'h00 && station_address_in <= 8'hC7;
	property p_own; frame_end_in && frame_addr_in == station_address_in && ok |=> addr_match_out; endproperty
	a_own: assert property (p_own) else $error("own address missed");
	property p_bc; frame_end_in && station_address_in == 8'h00 && frame_addr_in == 8'hFF |=> addr_match_out; endproperty
	a_bc: assert property (p_bc) else $error("address FF missed");
	property p_rt; line_rate_select_in == 3'h7 |=> bit_period_out == 16'h00D9; endproperty
	a_rt: assert property (p_rt) else $error("bit period wrong");
	property p_en; cfg_write_in && remote_config_write_enable_in |=> cfg_write_out && !cfg_write_refused_out; endproperty
	a_en: assert property (p_en) else $error("enabled write lost");
	property p_rf; cfg_write_in && !remote_config_write_enable_in && !op |=> cfg_write_refused_out && !cfg_write_out;
	endproperty
	a_rf: assert property (p_rf) else $error("write not refused");
	property p_op; cfg_write_in && op |=> cfg_write_out; endproperty
	a_op: assert property (p_op) else $error("open register blocked");
	property p_t0; (frame_gap_timeout_in == 7'h00) [*2] |-> !relay_alert_out; endproperty
	a_t0: assert property (p_t0) else $error("alert while disabled");
	property p_r0; addr_match_out && reply_delay_select_in == 3'h0 && reply_ready_in ##1 reply_ready_in |=> reply_go_out;
	endproperty
	a_r0: assert property (p_r0) else $error("reply late");
endmodule // mbl_chk
bind mbl_link_cfg mbl_chk mbl_chk_i (.clk_sys_in, .srst_in, .frame_end_in, .cfg_write_in, .remote_config_write_enable_in,
	.reply_ready_in, .addr_match_out, .cfg_write_out, .cfg_write_refused_out, .reply_go_out, .relay_alert_out,
	.station_address_in, .frame_addr_in, .cfg_write_reg_in, .bit_period_out, .line_rate_select_in,
	.reply_delay_select_in, .frame_gap_timeout_in);

// ### tb/mbl_master.sv
// Remote master model feeding framer events
`timescale 1ns/1ns
module mbl_master(input wire clk, output reg fe, output reg [7:0] fa, output reg cw, output reg [7:0] cr,
	output reg [15:0] cd, output reg rdy);
	initial {fe, fa, cw, cr, cd, rdy} = 0;
	// Released fields show inverted data, not stale
	task frame(input [7:0] a); begin @(posedge clk); #1 fe = 1; fa = a; @(posedge clk); #1 fe = 0; fa = ~a; end endtask
	task write(input [7:0] r, input [15:0] d); begin @(posedge clk); #1 cw = 1; cr = r; cd = d;
		@(posedge clk); #1 cw = 0; cr = ~r; cd = ~d; end endtask
endmodule // mbl_master

// ### tb/mbl_link_cfg_tb.sv
// Testbench for the link config block
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("unexpected %0t %h %h", $time, a, b); end end
module mbl_link_cfg_tb;
	reg clk = 0, srst = 1, en = 0;
	reg [7:0] sa = 0;
	reg [6:0] to = 0;
	reg [2:0] rs = 0, ds = 0;
	wire fe, cw, rdy, am, wo, wref, ra, go;
	wire [7:0] fa, cr, wr;
	wire [15:0] cd, wd, bp;
	integer n_mismatch = 0, samples_checked = 0, i;
	integer rate [0:7] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
	always #20 clk = ~clk;
	mbl_master mbl_master_i (.clk(clk), .fe(fe), .fa(fa), .cw(cw), .cr(cr), .cd(cd), .rdy(rdy));
	// Short second counts keep the gap test quick
	mbl_link_cfg #(.SEC_CYCLES(10)) mbl_link_cfg_i (.clk_sys_in(clk), .srst_in(srst), .station_address_in(sa),
		.line_rate_select_in(rs), .remote_config_write_enable_in(en), .frame_gap_timeout_in(to),
		.reply_delay_select_in(ds), .frame_end_in(fe), .frame_addr_in(fa), .cfg_write_in(cw), .cfg_write_reg_in(cr),
		.cfg_write_data_in(cd), .reply_ready_in(rdy), .bit_period_out(bp), .addr_match_out(am), .cfg_write_out(wo),
		.cfg_write_reg_out(wr), .cfg_write_data_out(wd), .cfg_write_refused_out(wref), .relay_alert_out(ra),
		.reply_go_out(go));
	task f(input [7:0] a); mbl_master_i.frame(a); endtask
	task w(input [7:0] r, input [15:0] d); mbl_master_i.write(r, d); endtask
	task tick(input integer n); begin repeat (n) @(posedge clk); #1; end endtask
	task wrap_up; begin $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]"); else $display("[ FAIL ]");
		$finish; end endtask
	task t_addr; begin
		sa = 8'h05; f(8'h05); `CHK(am, 1'b1)
		f(8'h06); `CHK(am, 1'b0)
		sa = 8'hC8; f(8'hC8); `CHK(am, 1'b0)
		sa = 8'h00; f(8'hFF); `CHK(am, 1'b1)
		f(8'h00); `CHK(am, 1'b0)
	end endtask
	task t_wr; begin
		w(8'h03, 16'hA5A5); `CHK({wo, wref}, 2'b01)
		w(8'h04, 16'h1234); `CHK({wo, wref, wr, wd}, {2'b10, 8'h04, 16'h1234})
		w(8'h05, 16'h5678); `CHK({wo, wref}, 2'b10)
		en = 1; w(8'h03, 16'h0F0F); `CHK({wo, wr, wd}, {1'b1, 8'h03, 16'h0F0F})
	end endtask
	task t_rate; for (i = 0; i < 8; i++) begin rs = i[2:0]; tick(2); `CHK(bp, 16'((25000000 + rate[i] / 2) / rate[i])) end
	endtask
	task t_gap; begin
		to = 7'h02; f(8'h01); tick(20); `CHK(ra, 1'b0)
		tick(1); `CHK(ra, 1'b1)
		f(8'h01); tick(1); `CHK(ra, 1'b0)
		to = 7'h00; tick(40); `CHK(ra, 1'b0)
	end endtask
	task t_rep; begin
		rs = 3'h7; sa = 8'h09; mbl_master_i.rdy = 1; tick(4); f(8'h09); tick(2); `CHK(go, 1'b1)
		rs = 3'h5; ds = 3'h1; f(8'h09); i = 0;
		while (go !== 1'b1 && i < 80000) begin tick(1); i++; end
		`CHK(i, 10 * 11 * ((25000000 + rate[5] / 2) / rate[5]) + 2)
	end endtask
	initial begin
		tick(5); srst = 0;
		t_addr; t_wr; t_rate; t_gap; t_rep; wrap_up;
	end
endmodule // mbl_link_cfg_tb
